/* File: hdl/bfso_pkg.sv */
// Constants and types of the bit, flag and shift execution unit
package bfso_pkg;

  // ==========================================================
  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OPND   = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0c;
  localparam logic [7:0] ADDR_IOREG  = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_BIT_LSB = 8;
  localparam int STAT_SP_LSB  = 8;

  // Flag positions inside the processor_flag_register
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // ==========================================================
  // Operation codes
  localparam logic [4:0] OP_NOP   = 5'h00;
  localparam logic [4:0] OP_SLEEP = 5'h01;
  localparam logic [4:0] OP_WDR   = 5'h02;
  localparam logic [4:0] OP_BRK   = 5'h03;
  localparam logic [4:0] OP_PUSH  = 5'h04;
  localparam logic [4:0] OP_POP   = 5'h05;
  localparam logic [4:0] OP_IOSET = 5'h06;
  localparam logic [4:0] OP_IOCLR = 5'h07;
  localparam logic [4:0] OP_SHL   = 5'h08;
  localparam logic [4:0] OP_SHR   = 5'h09;
  localparam logic [4:0] OP_ROLC  = 5'h0a;
  localparam logic [4:0] OP_RORC  = 5'h0b;
  localparam logic [4:0] OP_SAR   = 5'h0c;
  localparam logic [4:0] OP_NIBX  = 5'h0d;
  localparam logic [4:0] OP_FSET  = 5'h0e;
  localparam logic [4:0] OP_FCLR  = 5'h0f;
  localparam logic [4:0] OP_TSTO  = 5'h10;
  localparam logic [4:0] OP_TLD   = 5'h11;
  localparam logic [4:0] OP_CSET  = 5'h12;
  localparam logic [4:0] OP_CCLR  = 5'h13;
  localparam logic [4:0] OP_NSET  = 5'h14;
  localparam logic [4:0] OP_NCLR  = 5'h15;
  localparam logic [4:0] OP_ZSET  = 5'h16;
  localparam logic [4:0] OP_ZCLR  = 5'h17;
  localparam logic [4:0] OP_ISET  = 5'h18;
  localparam logic [4:0] OP_ICLR  = 5'h19;
  localparam logic [4:0] OP_SSET  = 5'h1a;
  localparam logic [4:0] OP_SCLR  = 5'h1b;
  localparam logic [4:0] OP_VSET  = 5'h1c;
  localparam logic [4:0] OP_VCLR  = 5'h1d;
  localparam logic [4:0] OP_HCLR  = 5'h1e;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} bfso_state_type;

endpackage

/* File: hdl/bfso_top.sv */
// Bit, flag, shift and control-operation execution unit with APB access
// Notes on behaviour
// - push and pop use the stack, two cycles
// - I/O bit set or clear, others kept
// - shift left, zero into bit 0
// - shift right, zero into bit 7
// - rotate left through carry
// - rotate right through carry
// - arithmetic shift right keeps sign bit
// - swap nibbles in one cycle
// - set or clear selected flag bit
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - carry set and clear
// - negative set and clear
// - zero set and clear
// - interrupt enable set and clear
// - signed flag set and clear
// - overflow flag set and clear
// - half carry clear, other flags kept
// - sleep pulses sleep request, one cycle
// - watchdog restart pulse, one cycle
// - break only signals debug logic
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module bfso_top #(
  parameter int STACK_DEPTH = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sleep_req,
  output logic             wdt_restart,
  output logic             dbg_break,
  output logic      [7:0]  flags_out,
  output logic      [7:0]  io_out
);

  localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  typedef struct packed {
    bfso_pkg::bfso_state_type     state;
    logic [4:0]                   op;
    logic [2:0]                   bsel;
    logic [7:0]                   opnd;
    logic [7:0]                   result;
    logic [7:0]                   flags;
    logic [7:0]                   io;
    logic [SPW-1:0]               sp;
    logic [STACK_DEPTH-1:0][7:0]  stack;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic                         sleep;
    logic                         wdt;
    logic                         brk;
  } bfso_regs_type;

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // ==========================================================
  // State
  bfso_regs_type s_r;
  bfso_regs_type s_nxt;
  logic          setup;
  logic          access;
  logic          busy;
  logic [7:0]    d;
  logic          c;

  assign setup  = psel && !penable;
  assign access = psel && penable && s_r.pready;
  assign busy   = (s_r.state != bfso_pkg::ST_IDLE);
  assign d      = s_r.opnd;
  assign c      = s_r.flags[bfso_pkg::FLAG_C];

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.pready  = 1'b0;
    s_nxt.sleep   = 1'b0;
    s_nxt.wdt     = 1'b0;
    s_nxt.brk     = 1'b0;
    // Operation sequencer
    case (s_r.state)
      bfso_pkg::ST_IDLE:
        s_nxt.state = bfso_pkg::ST_IDLE;
      bfso_pkg::ST_EXEC:
      begin
        s_nxt.state = bfso_pkg::ST_IDLE;
        case (s_r.op)
          bfso_pkg::OP_PUSH:
          begin
            s_nxt.stack[s_r.sp] = d;
            s_nxt.sp    = s_r.sp + SPW'(1);
            s_nxt.state = bfso_pkg::ST_SECOND;
          end
          bfso_pkg::OP_POP:
          begin
            s_nxt.sp    = s_r.sp - SPW'(1);
            s_nxt.state = bfso_pkg::ST_SECOND;
          end
          bfso_pkg::OP_IOSET: s_nxt.io[s_r.bsel] = 1'b1;
          bfso_pkg::OP_IOCLR: s_nxt.io[s_r.bsel] = 1'b0;
          bfso_pkg::OP_SHL:
          begin
            s_nxt.result = {d[6:0], 1'b0};
            s_nxt.flags[bfso_pkg::FLAG_C] = d[7];
          end
          bfso_pkg::OP_SHR:
          begin
            s_nxt.result = {1'b0, d[7:1]};
            s_nxt.flags[bfso_pkg::FLAG_C] = d[0];
          end
          bfso_pkg::OP_ROLC:
          begin
            s_nxt.result = {d[6:0], c};
            s_nxt.flags[bfso_pkg::FLAG_C] = d[7];
          end
          bfso_pkg::OP_RORC:
          begin
            s_nxt.result = {c, d[7:1]};
            s_nxt.flags[bfso_pkg::FLAG_C] = d[0];
          end
          bfso_pkg::OP_SAR:  s_nxt.result = {d[7], d[7:1]};
          bfso_pkg::OP_NIBX: s_nxt.result = {d[3:0], d[7:4]};
          bfso_pkg::OP_FSET: s_nxt.flags[s_r.bsel] = 1'b1;
          bfso_pkg::OP_FCLR: s_nxt.flags[s_r.bsel] = 1'b0;
          bfso_pkg::OP_TSTO:
            s_nxt.flags[bfso_pkg::FLAG_T] = d[s_r.bsel];
          bfso_pkg::OP_TLD:
          begin
            s_nxt.result = d;
            s_nxt.result[s_r.bsel] = s_r.flags[bfso_pkg::FLAG_T];
          end
          bfso_pkg::OP_CSET: s_nxt.flags[bfso_pkg::FLAG_C] = 1'b1;
          bfso_pkg::OP_CCLR: s_nxt.flags[bfso_pkg::FLAG_C] = 1'b0;
          bfso_pkg::OP_NSET: s_nxt.flags[bfso_pkg::FLAG_N] = 1'b1;
          bfso_pkg::OP_NCLR: s_nxt.flags[bfso_pkg::FLAG_N] = 1'b0;
          bfso_pkg::OP_ZSET: s_nxt.flags[bfso_pkg::FLAG_Z] = 1'b1;
          bfso_pkg::OP_ZCLR: s_nxt.flags[bfso_pkg::FLAG_Z] = 1'b0;
          bfso_pkg::OP_ISET: s_nxt.flags[bfso_pkg::FLAG_I] = 1'b1;
          bfso_pkg::OP_ICLR: s_nxt.flags[bfso_pkg::FLAG_I] = 1'b0;
          bfso_pkg::OP_SSET: s_nxt.flags[bfso_pkg::FLAG_S] = 1'b1;
          bfso_pkg::OP_SCLR: s_nxt.flags[bfso_pkg::FLAG_S] = 1'b0;
          bfso_pkg::OP_VSET: s_nxt.flags[bfso_pkg::FLAG_V] = 1'b1;
          bfso_pkg::OP_VCLR: s_nxt.flags[bfso_pkg::FLAG_V] = 1'b0;
          bfso_pkg::OP_HCLR: s_nxt.flags[bfso_pkg::FLAG_H] = 1'b0;
          bfso_pkg::OP_SLEEP: s_nxt.sleep = 1'b1;
          bfso_pkg::OP_WDR:   s_nxt.wdt   = 1'b1;
          bfso_pkg::OP_BRK:   s_nxt.brk   = 1'b1;
          default:            s_nxt.state = bfso_pkg::ST_IDLE;
        endcase
      end
      bfso_pkg::ST_SECOND:
      begin
        if (s_r.op == bfso_pkg::OP_POP)
          s_nxt.result = s_r.stack[s_r.sp];
        s_nxt.state = bfso_pkg::ST_IDLE;
      end
      default:
        s_nxt.state = bfso_pkg::ST_IDLE;
    endcase
    // APB setup: read data and error are ready for the access cycle
    if (setup)
    begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = pwrite && busy;
      s_nxt.prdata  = bfso_pkg::WORD_ZERO;
      if (paddr == bfso_pkg::ADDR_CTRL)
      begin
        s_nxt.prdata[bfso_pkg::CTRL_OP_LSB +: 5]  = s_r.op;
        s_nxt.prdata[bfso_pkg::CTRL_BIT_LSB +: 3] = s_r.bsel;
      end
      else if (paddr == bfso_pkg::ADDR_OPND)
        s_nxt.prdata[7:0] = s_r.opnd;
      else if (paddr == bfso_pkg::ADDR_RESULT)
        s_nxt.prdata[7:0] = s_r.result;
      else if (paddr == bfso_pkg::ADDR_FLAGS)
        s_nxt.prdata[7:0] = s_r.flags;
      else if (paddr == bfso_pkg::ADDR_IOREG)
        s_nxt.prdata[7:0] = s_r.io;
      else if (paddr == bfso_pkg::ADDR_STATUS)
      begin
        s_nxt.prdata[0] = busy;
        s_nxt.prdata[bfso_pkg::STAT_SP_LSB +: SPW] = s_r.sp;
      end
      else
        s_nxt.pslverr = 1'b1;
    end
    else if (!psel || access)
      s_nxt.pslverr = 1'b0;
    // APB write takes effect at the completing edge only
    if (access && pwrite && !s_r.pslverr)
    begin
      if (paddr == bfso_pkg::ADDR_CTRL)
      begin
        s_nxt.op    = pwdata[bfso_pkg::CTRL_OP_LSB +: 5];
        s_nxt.bsel  = pwdata[bfso_pkg::CTRL_BIT_LSB +: 3];
        s_nxt.state = bfso_pkg::ST_EXEC;
      end
      else if (paddr == bfso_pkg::ADDR_OPND)
        s_nxt.opnd = pwdata[7:0];
      else if (paddr == bfso_pkg::ADDR_FLAGS)
        s_nxt.flags = pwdata[7:0];
      else if (paddr == bfso_pkg::ADDR_IOREG)
        s_nxt.io = pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r         <= '0;
      s_r.state   <= bfso_pkg::ST_IDLE;
      s_r.flags   <= bfso_pkg::BYTE_RESET;
      s_r.io      <= bfso_pkg::BYTE_RESET;
    end
    else
      s_r <= s_nxt;
  end

  assign prdata      = s_r.prdata;
  assign pready      = s_r.pready;
  assign pslverr     = s_r.pslverr;
  assign sleep_req   = s_r.sleep;
  assign wdt_restart = s_r.wdt;
  assign dbg_break   = s_r.brk;
  assign flags_out   = s_r.flags;
  assign io_out      = s_r.io;

  // ==========================================================
  // Checks
  logic ex;
  assign ex = (s_r.state == bfso_pkg::ST_EXEC);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_PUSH_POP_TWO: assert property (
    ex && (s_r.op == bfso_pkg::OP_PUSH || s_r.op == bfso_pkg::OP_POP)
    |=> s_r.state == bfso_pkg::ST_SECOND ##1 s_r.state == bfso_pkg::ST_IDLE)
    else $error("push or pop not two cycles");
  AST_PUSH_POP_DATA: assert property (
    ex && s_r.op == bfso_pkg::OP_PUSH ##2 ex && s_r.op == bfso_pkg::OP_POP
    |=> ##1 s_r.result == $past(s_r.opnd, 4))
    else $error("pop did not return pushed byte");
  AST_IO_BIT: assert property (
    ex && s_r.op == bfso_pkg::OP_IOSET |=> s_r.io ==
    ($past(s_r.io) | (8'h01 << $past(s_r.bsel))))
    else $error("io bit set wrong");
  AST_SHL: assert property (
    ex && s_r.op == bfso_pkg::OP_SHL |=> s_r.result ==
    {$past(s_r.opnd[6:0]), 1'b0} && s_r.flags[0] == $past(s_r.opnd[7]))
    else $error("shift left wrong");
  AST_SHR: assert property (
    ex && s_r.op == bfso_pkg::OP_SHR |=> s_r.result ==
    {1'b0, $past(s_r.opnd[7:1])} && s_r.flags[0] == $past(s_r.opnd[0]))
    else $error("shift right wrong");
  AST_ROL: assert property (
    ex && s_r.op == bfso_pkg::OP_ROLC |=> s_r.result ==
    {$past(s_r.opnd[6:0]), $past(c)} && c == $past(s_r.opnd[7]))
    else $error("rotate left wrong");
  AST_ROR: assert property (
    ex && s_r.op == bfso_pkg::OP_RORC |=> s_r.result ==
    {$past(c), $past(s_r.opnd[7:1])} && c == $past(s_r.opnd[0]))
    else $error("rotate right wrong");
  AST_SAR: assert property (
    ex && s_r.op == bfso_pkg::OP_SAR |=> s_r.result[7] == s_r.result[6])
    else $error("sign not kept");
  AST_SWAP: assert property (
    ex && s_r.op == bfso_pkg::OP_NIBX |=> s_r.result[3:0] ==
    $past(s_r.opnd[7:4]) && s_r.result[7:4] == $past(s_r.opnd[3:0]))
    else $error("nibble swap wrong");
  AST_TSTORE: assert property (
    ex && s_r.op == bfso_pkg::OP_TSTO |=> s_r.flags[6] ==
    $past(s_r.opnd[s_r.bsel]) && $stable(s_r.opnd))
    else $error("transfer store wrong");
  AST_HCLR: assert property (
    ex && s_r.op == bfso_pkg::OP_HCLR |=> s_r.flags ==
    ($past(s_r.flags) & 8'hdf))
    else $error("half carry clear wrong");
  AST_SLEEP: assert property (
    ex && s_r.op == bfso_pkg::OP_SLEEP |=> sleep_req && $stable(s_r.flags)
    ##1 !sleep_req)
    else $error("sleep pulse wrong");
  AST_WDR: assert property (
    wdt_restart |-> $past(ex && s_r.op == bfso_pkg::OP_WDR))
    else $error("watchdog pulse without cause");
  AST_NOP: assert property (
    ex && s_r.op == bfso_pkg::OP_NOP && !access |=> $stable(s_r.flags) &&
    $stable(s_r.result) && $stable(s_r.io) && !busy)
    else $error("no-op changed state");

endmodule // bfso_top

`default_nettype wire

/* File: test/bfso_apb_master.sv */
// APB master model standing in for the core's decode side
`timescale 1ns/1ps
`default_nettype none
module bfso_apb_master (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [7:0]  req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  output logic      [31:0] rsp_data,
  output logic             rsp_err,
  output logic             done
);
  logic [1:0] phase_r;
  // ==========================================================
  // Setup, then access held until pready is seen at an edge
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r <= 2'h0;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 8'h00;
      pwdata  <= 32'h0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (phase_r == 2'h0 && req)
      begin
        psel    <= 1'b1;
        pwrite  <= req_wr;
        paddr   <= req_addr;
        pwdata  <= req_wdata;
        phase_r <= 2'h1;
      end
      else if (phase_r == 2'h1)
      begin
        penable <= 1'b1;
        phase_r <= 2'h2;
      end
      else if (phase_r == 2'h2 && pready)
      begin
        rsp_data <= prdata;
        rsp_err  <= pslverr;
        psel     <= 1'b0;
        penable  <= 1'b0;
        done     <= 1'b1;
        phase_r  <= 2'h0;
      end
    end
  end
endmodule // bfso_apb_master
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench of the bit, flag and shift unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk, rstn, req, req_wr, rsp_err, done;
  logic        psel, penable, pwrite, pready, pslverr;
  logic        sleep_req, wdt_restart, dbg_break;
  logic [7:0]  req_addr, paddr, flags_out, io_out;
  logic [31:0] req_wdata, rsp_data, pwdata, prdata;
  logic [7:0]  n_sl = 8'h00, n_wd = 8'h00, n_bk = 8'h00;
  logic [7:0]  e_sl, e_wd, e_bk, exp_f, exp_io, exp_r;
  logic [7:0]  stack_q[$];
  int          err_count = 0, compares = 0, cycles = 0;
  localparam logic [2:0] FIDX [6] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3};

  bfso_top u_bfso_top (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_req, .wdt_restart,
    .dbg_break, .flags_out, .io_out);
  bfso_apb_master u_bfso_apb_master (.sys_clk, .rstn, .req, .req_wr,
    .req_addr, .req_wdata, .prdata, .pready, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata, .rsp_data, .rsp_err, .done);

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Pulse counters and hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    n_sl <= n_sl + 8'(sleep_req);
    n_wd <= n_wd + 8'(wdt_restart);
    n_bk <= n_bk + 8'(dbg_break);
    if (cycles == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    req       <= 1'b1;
    req_wr    <= wr;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk iff done === 1'b1);
  endtask

  // ==========================================================
  // One operation through the registers, checked against the model
  task automatic run_op(input logic [4:0] op, input logic [2:0] b,
                        input logic [7:0] d);
    int k;
    logic [31:0] m;
    apb(1'b1, bfso_pkg::ADDR_OPND, {24'h0, d});
    apb(1'b1, bfso_pkg::ADDR_CTRL, {21'h0, b, 3'h0, op});
    k = 0;
    do
    begin
      apb(1'b0, bfso_pkg::ADDR_STATUS, 32'h0);
      k++;
    end
    while (rsp_data[0] !== 1'b0 && k < 20);
    cmp("busy", {31'h0, rsp_data[0]}, 32'h0);
    case (op)
      5'h01: e_sl++;
      5'h02: e_wd++;
      5'h03: e_bk++;
      5'h04: stack_q.push_back(d);
      5'h05: exp_r = stack_q.pop_back();
      5'h06: exp_io[b] = 1'b1;
      5'h07: exp_io[b] = 1'b0;
      5'h08: {exp_f[0], exp_r} = {d, 1'b0};
      5'h09: {exp_r, exp_f[0]} = {1'b0, d};
      5'h0a: {exp_f[0], exp_r} = {d, exp_f[0]};
      5'h0b: {exp_r, exp_f[0]} = {exp_f[0], d};
      5'h0c: exp_r = {d[7], d[7:1]};
      5'h0d: exp_r = {d[3:0], d[7:4]};
      5'h0e: exp_f[b] = 1'b1;
      5'h0f: exp_f[b] = 1'b0;
      5'h10: exp_f[6] = d[b];
      5'h11: exp_r = (d & ~(8'h01 << b)) | (8'(exp_f[6]) << b);
      5'h1e: exp_f[5] = 1'b0;
      default: if (op >= 5'h12) exp_f[FIDX[3'((op - 5'h12) >> 1)]] = ~op[0];
    endcase
    if (op inside {5'h05, [5'h08:5'h0d], 5'h11})
    begin
      apb(1'b0, bfso_pkg::ADDR_RESULT, 32'h0);
      cmp("result", rsp_data, {24'h0, exp_r});
    end
    // Carry after the arithmetic shift is left open
    m = (op == 5'h0c) ? 32'hfe : 32'hff;
    apb(1'b0, bfso_pkg::ADDR_FLAGS, 32'h0);
    cmp("flags", rsp_data & m, {24'h0, exp_f} & m);
    cmp("flags_out", {24'h0, flags_out} & m, {24'h0, exp_f} & m);
    cmp("io", {24'h0, io_out}, {24'h0, exp_io});
    cmp("pulses", {8'h0, n_sl, n_wd, n_bk}, {8'h0, e_sl, e_wd, e_bk});
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {rstn, req, req_wr, req_addr, req_wdata} = '0;
    {e_sl, e_wd, e_bk} = '0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, bfso_pkg::ADDR_FLAGS, 32'h0);
    cmp("flags_rst", rsp_data, bfso_pkg::WORD_ZERO);
    apb(1'b0, bfso_pkg::ADDR_STATUS, 32'h0);
    cmp("status_rst", rsp_data, bfso_pkg::WORD_ZERO);
    apb(1'b1, bfso_pkg::ADDR_FLAGS, 32'h21);
    exp_f = 8'h21;
    apb(1'b1, bfso_pkg::ADDR_IOREG, 32'h5a);
    exp_io = 8'h5a;
    apb(1'b0, 8'h20, 32'h0);
    cmp("unmapped", {rsp_err, rsp_data[30:0]}, 32'h80000000);
    run_op(5'h04, 3'h0, 8'h3c);
    run_op(5'h04, 3'h0, 8'ha5);
    run_op(5'h05, 3'h0, 8'h00);
    run_op(5'h05, 3'h0, 8'h00);
    for (int p = 0; p < 2; p++)
      for (int op = 0; op < 31; op++)
        run_op(5'(op), 3'(op) ^ (p != 0 ? 3'h5 : 3'h0),
               8'h96 ^ 8'(op * 29) ^ (p != 0 ? 8'hff : 8'h00));
    end_sim();
  end
endmodule // testbench
`default_nettype wire
